//--- pbc_consts.svh
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// ****************************************************************
// Register address and field positions
// ****************************************************************
`define PBC_ADDR_CTRL      5'h00
`define PBC_BIT_SPEED      13
`define PBC_BIT_AN_EN      12
`define PBC_BIT_ISOLATE    10
`define PBC_BIT_RESTART    9
`define PBC_BIT_DUPLEX     8
`define PBC_BIT_COL_TEST   7

// ****************************************************************
// Reset values and strap handling
// ****************************************************************
`define PBC_RST_SPEED      1'h1
`define PBC_RST_AN_EN      1'h1
`define PBC_RST_RESTART    1'h0
`define PBC_RST_DUPLEX     1'h1
`define PBC_RST_COL_TEST   1'h0
`define PBC_RST_ISOLATE    1'h1
`define PBC_ISO_STRAP_ADDR 5'h00
`define PBC_STRAP_WAIT     2'h3

`endif

//--- pbc_pkg.sv
`default_nettype none
package pbc_pkg;

  // Request from the serial management engine
  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [4:0]  addr;
    logic [15:0] wrData;
  } pbc_mgmt_req_s;

  // Outputs of the physical layer core toward the MAC
  typedef struct packed {
    logic       txClk;
    logic       rxClk;
    logic       rxValid;
    logic       rxErr;
    logic [3:0] rxData;
    logic       col;
    logic       crs;
  } pbc_mii_rx_s;

  // Transmit inputs from the MAC
  typedef struct packed {
    logic [3:0] txData;
    logic       txEn;
    logic       txErr;
  } pbc_mii_tx_s;

  // Strap capture sequencing
  typedef enum logic [1:0] {
    PBC_STRAP_WAIT_ST = 2'b00,
    PBC_STRAP_DONE_ST = 2'b01
  } pbc_strap_e;

endpackage : pbc_pkg
`default_nettype wire

//--- pbc_mii_isolate.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_mii_isolate (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 isolate,
  input  wire logic                 colTest,
  input  wire pbc_pkg::pbc_mii_rx_s coreRx,
  input  wire pbc_pkg::pbc_mii_tx_s macTx,
  output var  pbc_pkg::pbc_mii_rx_s miiOut,
  output logic                      miiOutOe,
  output var  pbc_pkg::pbc_mii_tx_s coreTx
);
  import pbc_pkg::*;

  logic        txEnLive;
  logic        colOut;
  pbc_mii_rx_s nxt_miiOut;
  pbc_mii_tx_s nxt_coreTx;
  logic        oe_ff;
  pbc_mii_rx_s miiOut_ff;
  pbc_mii_tx_s coreTx_ff;

  // ****************************************************************
  // Transmit gating and collision echo
  // ****************************************************************
  // Isolated MAC inputs are dropped before they reach the core
  assign txEnLive   = macTx.txEn & ~isolate;                   // R1 R4
  assign nxt_coreTx = isolate ? '0 : macTx;                    // R1
  // Echo enable onto collision; held off while isolated anyway
  assign colOut     = coreRx.col | (colTest & txEnLive);       // R12

  // Clocks pass through; only their enable is registered
  always_comb begin
    nxt_miiOut     = coreRx;
    nxt_miiOut.col = colOut;
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Pin enable low floats every MAC-facing output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_ff     <= 1'h0;
      miiOut_ff <= '0;
      coreTx_ff <= '0;
    end else begin
      oe_ff     <= ~isolate;                                   // R2
      miiOut_ff <= nxt_miiOut;
      coreTx_ff <= nxt_coreTx;
    end
  end

  // Clock pins keep live edges; a registered clock would be useless
  always_comb begin
    miiOut       = miiOut_ff;
    miiOut.txClk = coreRx.txClk;
    miiOut.rxClk = coreRx.rxClk;
  end
  assign miiOutOe = oe_ff;                                     // R2
  assign coreTx   = coreTx_ff;

endmodule : pbc_mii_isolate
`default_nettype wire

//--- pbc_basic_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.svh"

// Behaviour
// R1: Isolated: ignore MAC transmit inputs
// R2: Isolated: float all MII outputs
// R3: Isolated: reference clock and management still work
// R4: Isolated: idle on fast pair, float slow
// R5: Isolated: ignore receive inputs, link disabled
// R6: Zero strapped address resets to isolated
// R7: Restart bit sets, self-clears when negotiation starts
// R8: Restart ignored while negotiation disabled
// R9: Writing restart zero never disturbs negotiation
// R10: Duplex bit selects full or half
// R11: Duplex bit is control, not status
// R12: Collision test echoes transmit enable onto collision
// R13: Reserved bits written zero, read as zero
// R14: Negotiation on overrides speed and duplex bits
module pbc_basic_control (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [4:0]             strappedPhyAddress,
  input  wire pbc_pkg::pbc_mgmt_req_s mgmtReq,
  output logic [15:0]                 mgmtRdData,
  output logic                        mgmtRdHit,
  input  wire pbc_pkg::pbc_mii_rx_s   coreRx,
  input  wire pbc_pkg::pbc_mii_tx_s   macTx,
  output var  pbc_pkg::pbc_mii_rx_s   miiOut,
  output logic                        miiOutOe,
  output var  pbc_pkg::pbc_mii_tx_s   coreTx,
  input  wire logic                   refClockIn,
  input  wire logic                   refClockEnable,
  output logic                        refClockOut,
  output logic                        fastTxSendIdle,
  output logic                        slowTxPairOe,
  output logic                        rxInputsIgnore,
  output logic                        linkEnable,
  output logic                        anRestartReq,
  input  wire logic                   anStarted,
  output logic                        anEnable,
  input  wire logic                   negFullDuplex,
  input  wire logic                   negSpeed100,
  output logic                        fullDuplex,
  output logic                        speed100
);
  import pbc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [4:0]  strapSync1_ff;
  logic [4:0]  strapSync2_ff;
  logic [4:0]  strapSync3_ff;
  logic [1:0]  strapCnt_ff;
  pbc_strap_e  strapSt_ff;
  pbc_strap_e  nxt_strapSt;
  logic        strapStable;
  logic        strapLoad;
  logic        speed_ff;
  logic        anEn_ff;
  logic        isolate_ff;
  logic        restart_ff;
  logic        duplex_ff;
  logic        colTest_ff;
  logic        nxt_restart;
  logic        nxt_isolate;
  logic        ctrlWr;
  logic        ctrlRd;
  logic        restartSet;
  logic [15:0] ctrlView;
  logic [15:0] rdData_ff;
  logic        rdHit_ff;

  // Address decode used by both the write and read paths
  function automatic logic hitsCtrl(input logic [4:0] a);
    hitsCtrl = (a == `PBC_ADDR_CTRL);
  endfunction : hitsCtrl

  // ****************************************************************
  // Strap synchroniser and isolate default capture
  // ****************************************************************
  // Strap pins are asynchronous; three stages, stage 1 feeds stage 2 only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strapSync1_ff <= 5'h00;
      strapSync2_ff <= 5'h00;
      strapSync3_ff <= 5'h00;
    end else begin
      strapSync1_ff <= strappedPhyAddress;
      strapSync2_ff <= strapSync1_ff;
      strapSync3_ff <= strapSync2_ff;
    end
  end

  // Wait for the pipe to fill so reset zeros are never mistaken for a strap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strapCnt_ff <= 2'h0;
    end else if (strapCnt_ff != `PBC_STRAP_WAIT) begin
      strapCnt_ff <= strapCnt_ff + 2'h1;
    end
  end

  assign strapStable = (strapSync2_ff == strapSync3_ff);
  assign strapLoad   = (strapSt_ff == PBC_STRAP_WAIT_ST) &&
                       (strapCnt_ff == `PBC_STRAP_WAIT) && strapStable;

  always_comb begin
    case (strapSt_ff)
      PBC_STRAP_WAIT_ST: nxt_strapSt = strapLoad ? PBC_STRAP_DONE_ST
                                                 : PBC_STRAP_WAIT_ST;
      PBC_STRAP_DONE_ST: nxt_strapSt = PBC_STRAP_DONE_ST;
      default:           nxt_strapSt = PBC_STRAP_WAIT_ST;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strapSt_ff <= PBC_STRAP_WAIT_ST;
    end else begin
      strapSt_ff <= nxt_strapSt;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Management is never gated by isolate
  assign ctrlWr = mgmtReq.wrEn & hitsCtrl(mgmtReq.addr);       // R3
  assign ctrlRd = mgmtReq.rdEn & hitsCtrl(mgmtReq.addr);       // R3

  // Held isolated until the strap is known; safer than driving the MII
  always_comb begin
    nxt_isolate = isolate_ff;
    if (strapLoad) begin
      nxt_isolate = (strapSync3_ff == `PBC_ISO_STRAP_ADDR);    // R6
    end
    if (ctrlWr) begin
      nxt_isolate = mgmtReq.wrData[`PBC_BIT_ISOLATE];
    end
  end

  // Restart takes effect only with negotiation enabled after the write
  assign restartSet = ctrlWr & mgmtReq.wrData[`PBC_BIT_RESTART] &
                      mgmtReq.wrData[`PBC_BIT_AN_EN];          // R8

  // Written zero is ignored; set wins over the start acknowledge
  always_comb begin
    nxt_restart = restart_ff;
    if (anStarted) begin
      nxt_restart = 1'h0;                                      // R7
    end
    if (restartSet) begin
      nxt_restart = 1'h1;                                      // R7 R9
    end
    if (ctrlWr && !mgmtReq.wrData[`PBC_BIT_AN_EN]) begin
      nxt_restart = 1'h0;                                      // R8
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      isolate_ff <= `PBC_RST_ISOLATE;
      restart_ff <= `PBC_RST_RESTART;
    end else begin
      isolate_ff <= nxt_isolate;
      restart_ff <= nxt_restart;
    end
  end

  // Plain read-write fields; bits 15:14, 11 and 6:0 are not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_ff   <= `PBC_RST_SPEED;
      anEn_ff    <= `PBC_RST_AN_EN;
      duplex_ff  <= `PBC_RST_DUPLEX;
      colTest_ff <= `PBC_RST_COL_TEST;
    end else if (ctrlWr) begin
      speed_ff   <= mgmtReq.wrData[`PBC_BIT_SPEED];
      anEn_ff    <= mgmtReq.wrData[`PBC_BIT_AN_EN];
      duplex_ff  <= mgmtReq.wrData[`PBC_BIT_DUPLEX];           // R10
      colTest_ff <= mgmtReq.wrData[`PBC_BIT_COL_TEST];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Duplex reads back as written, never the live duplex state
  always_comb begin
    ctrlView                     = 16'h0000;                   // R13
    ctrlView[`PBC_BIT_SPEED]     = speed_ff;
    ctrlView[`PBC_BIT_AN_EN]     = anEn_ff;
    ctrlView[`PBC_BIT_ISOLATE]   = isolate_ff;
    ctrlView[`PBC_BIT_RESTART]   = restart_ff;                 // R7
    ctrlView[`PBC_BIT_DUPLEX]    = duplex_ff;                  // R11
    ctrlView[`PBC_BIT_COL_TEST]  = colTest_ff;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= 16'h0000;
      rdHit_ff  <= 1'h0;
    end else begin
      rdData_ff <= ctrlRd ? ctrlView : 16'h0000;
      rdHit_ff  <= ctrlRd;
    end
  end

  assign mgmtRdData = rdData_ff;
  assign mgmtRdHit  = rdHit_ff;

  // ****************************************************************
  // Mode outputs
  // ****************************************************************
  assign anEnable     = anEn_ff;
  assign anRestartReq = restart_ff & anEn_ff;                  // R7 R8
  // Negotiation result wins while enabled
  assign fullDuplex   = anEn_ff ? negFullDuplex : duplex_ff;   // R10 R14
  assign speed100     = anEn_ff ? negSpeed100 : speed_ff;      // R14

  // Line side behaviour while isolated
  assign fastTxSendIdle = isolate_ff;                          // R4
  assign slowTxPairOe   = ~isolate_ff;                         // R4
  assign rxInputsIgnore = isolate_ff;                          // R5
  assign linkEnable     = ~isolate_ff;                         // R5
  // Reference clock follows only its own enable
  assign refClockOut    = refClockIn & refClockEnable;         // R3

  // ****************************************************************
  // MII gating
  // ****************************************************************
  pbc_mii_isolate uMiiIsolate (
    .clk      (clk),
    .rst_b    (rst_b),
    .isolate  (isolate_ff),
    .colTest  (colTest_ff),
    .coreRx   (coreRx),
    .macTx    (macTx),
    .miiOut   (miiOut),
    .miiOutOe (miiOutOe),
    .coreTx   (coreTx)
  );

endmodule : pbc_basic_control
`default_nettype wire

//--- pbc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// MAC transmit side
// ****
module pbc_mac_model (
  input  wire logic                 clk,
  input  wire logic                 send,
  input  wire logic [3:0]           nib,
  output var  pbc_pkg::pbc_mii_tx_s macTx
);
  import pbc_pkg::*;
  logic [3:0] idleNib_ff = 4'h0;
  // Idle nibble toggles so stale data never looks valid
  always @(posedge clk) begin
    idleNib_ff   <= ~idleNib_ff;
    macTx.txEn   <= send;
    macTx.txErr  <= 1'b0;
    macTx.txData <= send ? nib : idleNib_ff;
  end
endmodule : pbc_mac_model
`default_nettype wire

//--- pbc_basic_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Control register checker
// ****
module pbc_basic_control_chk (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire pbc_pkg::pbc_mgmt_req_s mgmtReq,
  input wire logic [15:0]            mgmtRdData,
  input wire logic                   mgmtRdHit,
  input wire pbc_pkg::pbc_mii_tx_s   coreTx,
  input wire logic                   miiOutOe,
  input wire logic                   fastTxSendIdle,
  input wire logic                   slowTxPairOe,
  input wire logic                   linkEnable,
  input wire logic                   anRestartReq,
  input wire logic                   anEnable,
  input wire logic                   negFullDuplex,
  input wire logic                   fullDuplex
);
  import pbc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reads answered one cycle later, isolated or not
  property p_rdHit;
    mgmtReq.rdEn && mgmtReq.addr == 5'h00 |=> mgmtRdHit;
  endproperty
  a_rdHit: assert property (p_rdHit) else $error("read not answered");
  property p_txGate;
    fastTxSendIdle |=> coreTx == '0;
  endproperty
  a_txGate: assert property (p_txGate) else $error("tx leaked");
  property p_float;
    fastTxSendIdle |=> !miiOutOe;
  endproperty
  a_float: assert property (p_float) else $error("mii driven");
  property p_slow;
    slowTxPairOe == !fastTxSendIdle;
  endproperty
  a_slow: assert property (p_slow) else $error("slow pair drive");
  property p_link;
    linkEnable != fastTxSendIdle;
  endproperty
  a_link: assert property (p_link) else $error("link state");
  property p_setRst;
    mgmtReq.wrEn && mgmtReq.addr == 5'h00 && mgmtReq.wrData[12]
      && mgmtReq.wrData[9] |=> anRestartReq;
  endproperty
  a_setRst: assert property (p_setRst) else $error("restart lost");
  property p_rstOff;
    anRestartReq |-> anEnable;
  endproperty
  a_rstOff: assert property (p_rstOff) else $error("restart no neg");
  property p_dup;
    anEnable |-> fullDuplex == negFullDuplex;
  endproperty
  a_dup: assert property (p_dup) else $error("duplex override");
  property p_rsv;
    mgmtRdHit |-> mgmtRdData[6:0] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule : pbc_basic_control_chk
bind pbc_basic_control pbc_basic_control_chk i_chk (
  .clk(clk), .rst_b(rst_b), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
  .mgmtRdHit(mgmtRdHit), .coreTx(coreTx), .miiOutOe(miiOutOe),
  .fastTxSendIdle(fastTxSendIdle), .slowTxPairOe(slowTxPairOe),
  .linkEnable(linkEnable), .anRestartReq(anRestartReq),
  .anEnable(anEnable), .negFullDuplex(negFullDuplex),
  .fullDuplex(fullDuplex));
`default_nettype wire

//--- tb_pbc_basic_control.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Control register bench
// ****
module tb_pbc_basic_control;
  import pbc_pkg::*;
  logic          clk, rstB, refEn, anStarted, negFd, negSp, send;
  logic          refIn = 1'b0;
  logic [4:0]    strap;
  logic [3:0]    nib;
  pbc_mgmt_req_s req;
  pbc_mii_rx_s   coreRx, miiOut;
  pbc_mii_tx_s   macTx, coreTx;
  logic [15:0]   rdData;
  logic          rdHit, oe, refOut, idle, slowOe, rxIgn, link;
  logic          anReq, anEn, fd, sp;
  int            badCount, numChecks;
  pbc_basic_control i_dut (.clk(clk), .rst_b(rstB),
    .strappedPhyAddress(strap), .mgmtReq(req), .mgmtRdData(rdData),
    .mgmtRdHit(rdHit), .coreRx(coreRx), .macTx(macTx), .miiOut(miiOut),
    .miiOutOe(oe), .coreTx(coreTx), .refClockIn(refIn),
    .refClockEnable(refEn), .refClockOut(refOut), .fastTxSendIdle(idle),
    .slowTxPairOe(slowOe), .rxInputsIgnore(rxIgn), .linkEnable(link),
    .anRestartReq(anReq), .anStarted(anStarted), .anEnable(anEn),
    .negFullDuplex(negFd), .negSpeed100(negSp), .fullDuplex(fd),
    .speed100(sp));
  pbc_mac_model i_mac (.clk(clk), .send(send), .nib(nib), .macTx(macTx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reference clock toggles off the main clock edge
  always @(posedge clk) refIn <= ~refIn;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strap only matters at reset, so it changes with reset held
  task automatic doReset(input logic [4:0] s);
    @(posedge clk) rstB <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clk);
    rstB <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : doReset
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic h);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) req <= '0;
    #1;
    chk(16'(rdHit), 16'(h));
    chk(rdData, e);
  endtask : rd
  task automatic pulseTx(input logic v);
    @(posedge clk) send <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulseTx
  task automatic testIso;
    doReset(5'h00);
    rd(5'h00, 16'h3500, 1'b1);
    pulseTx(1'b1);
    chk(16'(coreTx), 16'h0000);
    chk(16'(oe), 16'h0000);
    chk(16'(refOut), 16'(refIn));
    chk(16'({idle, slowOe}), 16'h0002);
    chk(16'({rxIgn, link}), 16'h0002);
    // Two edges so both phases of the reference clock are seen gated
    @(posedge clk) refEn <= 1'b0;
    repeat (2) begin
      #1;
      chk(16'(refOut), 16'h0000);
      @(posedge clk);
    end
    refEn <= 1'b1;
    pulseTx(1'b0);
    $display("test isolate done");
  endtask : testIso
  task automatic testRun;
    doReset(5'h05);
    rd(5'h00, 16'h3100, 1'b1);
    chk(16'(oe), 16'h0001);
    // Receive data must reach the MAC pins once they are driven
    @(posedge clk) coreRx.rxData <= 4'h5;
    repeat (2) @(posedge clk);
    #1;
    chk(16'(miiOut.rxData), 16'h0005);
    rd(5'h01, 16'h0000, 1'b0);
    // Software keeps reserved bits zero; they must read back zero
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h0000, 1'b1);
    $display("test normal done");
  endtask : testRun
  task automatic testRestart;
    wr(5'h00, 16'h1200);
    chk(16'(anReq), 16'h0001);
    rd(5'h00, 16'h1200, 1'b1);
    wr(5'h00, 16'h1000);
    chk(16'(anReq), 16'h0001);
    @(posedge clk) anStarted <= 1'b1;
    @(posedge clk) anStarted <= 1'b0;
    #1;
    chk(16'(anReq), 16'h0000);
    wr(5'h00, 16'h0200);
    chk(16'(anReq), 16'h0000);
    rd(5'h00, 16'h0000, 1'b1);
    $display("test restart done");
  endtask : testRestart
  task automatic testDuplex;
    @(posedge clk) negFd <= 1'b1;
    wr(5'h00, 16'h0000);
    chk(16'({fd, sp}), 16'h0000);
    wr(5'h00, 16'h2100);
    chk(16'({fd, sp}), 16'h0003);
    wr(5'h00, 16'h1000);
    chk(16'({fd, sp}), 16'h0002);
    rd(5'h00, 16'h1000, 1'b1);
    $display("test duplex done");
  endtask : testDuplex
  task automatic testCol;
    wr(5'h00, 16'h0080);
    @(posedge clk) nib <= 4'hA;
    pulseTx(1'b1);
    chk(16'(miiOut.col), 16'h0001);
    chk(16'(coreTx), 16'h002A);
    pulseTx(1'b0);
    chk(16'(miiOut.col), 16'h0000);
    $display("test collision done");
  endtask : testCol
  task automatic tallyAndFinish;
    $display("checks=%0d mismatches=%0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tallyAndFinish
  // Tests need under a hundred cycles; this cuts a hang short
  initial begin
    #20000;
    badCount++;
    tallyAndFinish();
  end
  initial begin
    {rstB, refEn, anStarted, send} = 4'h4;
    {negFd, negSp, strap, nib} = '0;
    req = '0;
    coreRx = '0;
    testIso();
    testRun();
    testRestart();
    testDuplex();
    testCol();
    tallyAndFinish();
  end
endmodule : tb_pbc_basic_control
`default_nettype wire
